/* verilog/tmc_timer.sv */
/*
 * Sixteen-bit timer/counter with APB register access, input divider,
 * buffered wide access, special event reset and overflow interrupt.
 * Assumes one clock mclk_i; pads and the oscillator are asynchronous,
 * the compare unit signals are on mclk_i.
 */
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module tmc_timer (
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // external count sources
    input  wire logic        ext_count_input_i,
    input  wire logic        companion_osc_in_i,
    // shared port pins
    input  wire logic [1:0]  port_c_direction_i,
    input  wire logic [1:0]  port_c_latch_i,
    input  wire logic [1:0]  pad_in_i,
    output logic [1:0]       pad_out_o,
    output logic [1:0]       pad_oe_o,
    output logic [1:0]       port_c_read_o,
    // compare unit
    input  wire logic [3:0]  enhanced_cc_mode_field_i,
    input  wire logic        enhanced_cc_match_i,
    output logic             cc_enh_use_this_o,
    output logic             cc_std_use_this_o,
    output logic [15:0]      count_o,
    output tmc_pkg::tmc_mode_t mode_o,
    // interrupt
    output logic             irq_o
);
    import tmc_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [7:0]  ctrl_q;
    logic        osc_en_q;
    logic        ovf_mask_q;
    logic        ovf_flag_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [7:0]  hi_buf_q;
    logic [2:0]  div_q;
    logic        armed_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        irq_q;
    logic [1:0]  pad_meta_q;
    logic [1:0]  pad_sync_q;
    logic [1:0]  port_rd_q;
    logic [1:0]  pad_out_q;
    logic [1:0]  pad_oe_q;
    logic        cc_enh_q;
    logic        cc_std_q;
    tmc_mode_t   mode_q;

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    logic       setup;
    logic       done_wr;
    logic       wr_lo;
    logic       wr_hi;
    logic       rd_lo_setup;
    logic       run;
    logic       src_ext;
    logic       sync_byp;
    logic       wide;
    logic [1:0] div_sel;
    logic       pin_rise;
    logic       pin_fall;
    logic       osc_rise;
    logic       osc_fall;
    logic       ext_rise;
    logic       ext_fall;
    logic       src_tick;
    logic       div_tick;
    logic       inc;
    logic       wrap;
    logic       spev;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == TMC_OFS_CTRL) || (a == TMC_OFS_CNT_LO) ||
                    (a == TMC_OFS_CNT_HI) || (a == TMC_OFS_STATUS) ||
                    (a == TMC_OFS_MASK) || (a == TMC_OFS_AUX);
    endfunction

    function automatic logic [2:0] div_mask(input logic [1:0] sel);
        case (sel)
            2'b00:   div_mask = 3'h0;
            2'b01:   div_mask = 3'h1;
            2'b10:   div_mask = 3'h3;
            default: div_mask = 3'h7;
        endcase
    endfunction

    assign run      = ctrl_q[TMC_CTL_RUN];
    assign src_ext  = ctrl_q[TMC_CTL_SRC];
    assign sync_byp = ctrl_q[TMC_CTL_SYNC_BYP];
    assign wide     = ctrl_q[TMC_CTL_WIDE];
    assign div_sel  = ctrl_q[TMC_CTL_DIV_LSB +: 2];

    assign setup       = psel_i & ~penable_i;
    assign done_wr     = psel_i & penable_i & pready_q & pwrite_i;
    assign wr_lo       = done_wr & (paddr_i == TMC_OFS_CNT_LO);
    assign wr_hi       = done_wr & (paddr_i == TMC_OFS_CNT_HI);
    assign rd_lo_setup = setup & ~pwrite_i & (paddr_i == TMC_OFS_CNT_LO);

    // ---------------------------------------------------------------
    // count source
    // ---------------------------------------------------------------
    // each source synchronised on its own: a mux ahead of the flops could glitch
    tmc_ext_edge u_edge_pin (
        .mclk_i   (mclk_i),
        .srst_i   (srst_i),
        .raw_i    (ext_count_input_i),
        .bypass_i (sync_byp),
        .rise_o   (pin_rise),
        .fall_o   (pin_fall)
    );

    tmc_ext_edge u_edge_osc (
        .mclk_i   (mclk_i),
        .srst_i   (srst_i),
        .raw_i    (companion_osc_in_i),
        .bypass_i (sync_byp),
        .rise_o   (osc_rise),
        .fall_o   (osc_fall)
    );

    // the oscillator owns the shared pin while enabled
    assign ext_rise = osc_en_q ? osc_rise : pin_rise;
    assign ext_fall = osc_en_q ? osc_fall : pin_fall;

    // a rising edge counts only once a falling edge has been seen
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            armed_q <= 1'b0;
        end else if (!src_ext) begin
            armed_q <= 1'b0;
        end else if (ext_fall) begin
            armed_q <= 1'b1;
        end
    end

    // internal source ticks every mclk; sync bit ignored then
    assign src_tick = src_ext ? (ext_rise & armed_q) : 1'b1;

    // ---------------------------------------------------------------
    // input divider
    // ---------------------------------------------------------------
    assign div_tick = src_tick & ((div_q & div_mask(div_sel)) == div_mask(div_sel));

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            div_q <= TMC_DIV_RST;
        end else if (wr_lo) begin
            div_q <= TMC_DIV_RST;
        end else if (run && src_tick) begin
            div_q <= div_q + 3'h1;
        end
    end

    // ---------------------------------------------------------------
    // counter
    // ---------------------------------------------------------------
    assign inc  = run & div_tick;
    assign wrap = inc & (count_q == TMC_CNT_MAX);
    // unsynchronised edges are not trusted for the reset
    assign spev = enhanced_cc_match_i &
                  (enhanced_cc_mode_field_i == TMC_MODE_SPEV) &
                  ~(src_ext & sync_byp);

    always_comb begin
        count_d = count_q;
        if (inc) begin
            count_d = count_q + 16'h0001;
        end
        if (spev) begin
            count_d = TMC_CNT_RST;
        end
        // software write wins over the trigger
        if (wr_lo) begin
            if (wide) begin
                count_d = {hi_buf_q, pwdata_i[7:0]};
            end else begin
                count_d = {count_q[15:8], pwdata_i[7:0]};
            end
        end else if (wr_hi && !wide) begin
            count_d = {pwdata_i[7:0], count_q[7:0]};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            count_q <= TMC_CNT_RST;
        end else begin
            count_q <= count_d;
        end
    end

    // ---------------------------------------------------------------
    // high byte buffer
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            hi_buf_q <= 8'h00;
        end else if (wide && rd_lo_setup) begin
            hi_buf_q <= count_q[15:8];
        end else if (wide && wr_hi) begin
            hi_buf_q <= pwdata_i[7:0];
        end
    end

    // ---------------------------------------------------------------
    // control, mask and status registers
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ctrl_q     <= TMC_CTRL_RST;
            osc_en_q   <= 1'b0;
            ovf_mask_q <= 1'b0;
        end else if (done_wr) begin
            if (paddr_i == TMC_OFS_CTRL) begin
                ctrl_q <= pwdata_i[7:0];
            end
            if (paddr_i == TMC_OFS_AUX) begin
                osc_en_q <= pwdata_i[TMC_AUX_OSC_EN];
            end
            if (paddr_i == TMC_OFS_MASK) begin
                ovf_mask_q <= pwdata_i[TMC_STS_OVF];
            end
        end
    end

    // a wrap in the clearing cycle is kept
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ovf_flag_q <= 1'b0;
        end else if (wrap) begin
            ovf_flag_q <= 1'b1;
        end else if (done_wr && paddr_i == TMC_OFS_STATUS && pwdata_i[TMC_STS_OVF]) begin
            ovf_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= ovf_flag_q & ovf_mask_q;
        end
    end

    // ---------------------------------------------------------------
    // apb slave: one wait-free access phase, data latched at setup
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pready_q  <= 1'b1;
            pslverr_q <= ~is_mapped(paddr_i);
            prdata_q  <= 32'h0000_0000;
            if (!pwrite_i) begin
                case (paddr_i)
                    TMC_OFS_CTRL:   prdata_q <= {24'h000000, ctrl_q};
                    TMC_OFS_CNT_LO: prdata_q <= {24'h000000, count_q[7:0]};
                    TMC_OFS_CNT_HI: prdata_q <= {24'h000000,
                                                 wide ? hi_buf_q : count_q[15:8]};
                    TMC_OFS_STATUS: prdata_q <= {31'h00000000, ovf_flag_q};
                    TMC_OFS_MASK:   prdata_q <= {31'h00000000, ovf_mask_q};
                    TMC_OFS_AUX:    prdata_q <= {31'h00000000, osc_en_q};
                    default:        prdata_q <= 32'h0000_0000;
                endcase
            end
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // shared pins
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pad_meta_q <= 2'b00;
            pad_sync_q <= 2'b00;
        end else begin
            pad_meta_q <= pad_in_i;
            pad_sync_q <= pad_meta_q;
        end
    end

    // direction bit 1 means input; the oscillator overrides it
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pad_oe_q  <= 2'b00;
            pad_out_q <= 2'b00;
            port_rd_q <= 2'b00;
        end else begin
            pad_out_q <= port_c_latch_i;
            pad_oe_q  <= osc_en_q ? 2'b00 : ~port_c_direction_i;
            port_rd_q <= osc_en_q ? 2'b00 : pad_sync_q;
        end
    end

    // ---------------------------------------------------------------
    // timebase routing and mode report
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cc_enh_q <= 1'b0;
            cc_std_q <= 1'b0;
            mode_q   <= TMC_MODE_TIMER;
        end else begin
            cc_enh_q <= ctrl_q[TMC_CTL_CC_HI] | ctrl_q[TMC_CTL_CC_LO];
            cc_std_q <= ctrl_q[TMC_CTL_CC_HI];
            if (!src_ext) begin
                mode_q <= TMC_MODE_TIMER;
            end else if (sync_byp) begin
                mode_q <= TMC_MODE_ASYNC;
            end else begin
                mode_q <= TMC_MODE_SYNC;
            end
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign prdata_o          = prdata_q;
    assign pready_o          = pready_q;
    assign pslverr_o         = pslverr_q;
    assign irq_o             = irq_q;
    assign count_o           = count_q;
    assign pad_out_o         = pad_out_q;
    assign pad_oe_o          = pad_oe_q;
    assign port_c_read_o     = port_rd_q;
    assign cc_enh_use_this_o = cc_enh_q;
    assign cc_std_use_this_o = cc_std_q;
    assign mode_o            = mode_q;

endmodule

/* verilog/tmc_pkg.sv */
/*
 * Constants for the sixteen-bit timer/counter: register map, field positions,
 * reset values and encodings.
 * Assumes an APB master with 32-bit data and byte addresses.
 */
package tmc_pkg;

    // -----------------------------------------------------------------
    // register map (byte addresses)
    // -----------------------------------------------------------------
    localparam logic [7:0] TMC_OFS_CTRL    = 8'h00;
    localparam logic [7:0] TMC_OFS_CNT_LO  = 8'h04;
    localparam logic [7:0] TMC_OFS_CNT_HI  = 8'h08;
    localparam logic [7:0] TMC_OFS_STATUS  = 8'h0c;
    localparam logic [7:0] TMC_OFS_MASK    = 8'h10;
    localparam logic [7:0] TMC_OFS_AUX     = 8'h14;

    // -----------------------------------------------------------------
    // counter_control, aux and status fields
    // -----------------------------------------------------------------
    localparam int TMC_CTL_RUN      = 0;
    localparam int TMC_CTL_SRC      = 1;
    localparam int TMC_CTL_SYNC_BYP = 2;
    localparam int TMC_CTL_CC_LO    = 3;
    localparam int TMC_CTL_DIV_LSB  = 4;
    localparam int TMC_CTL_CC_HI    = 6;
    localparam int TMC_CTL_WIDE     = 7;
    localparam int TMC_AUX_OSC_EN   = 0;
    localparam int TMC_STS_OVF      = 0;

    // -----------------------------------------------------------------
    // reset values and encodings
    // -----------------------------------------------------------------
    localparam logic [7:0]  TMC_CTRL_RST   = 8'h00;
    localparam logic [15:0] TMC_CNT_RST    = 16'h0000;
    localparam logic [15:0] TMC_CNT_MAX    = 16'hffff;
    localparam logic [2:0]  TMC_DIV_RST    = 3'h0;
    localparam logic [3:0]  TMC_MODE_SPEV  = 4'hb;

    typedef enum logic [1:0] {
        TMC_MODE_TIMER = 2'b00,
        TMC_MODE_SYNC  = 2'b01,
        TMC_MODE_ASYNC = 2'b10
    } tmc_mode_t;

endpackage

/* verilog/tmc_ext_edge.sv */
/*
 * Synchroniser and edge detector for the external count input.
 * Assumes the raw input is asynchronous to mclk_i.
 */
`timescale 1ns/1ps
module tmc_ext_edge (
    input  wire logic mclk_i,
    input  wire logic srst_i,
    input  wire logic raw_i,
    input  wire logic bypass_i,
    output logic      rise_o,
    output logic      fall_o
);
    import tmc_pkg::*;

    logic meta_q;
    logic sync_q;
    logic last_q;
    logic rise_dly_q;
    logic rise_now;

    // ---------------------------------------------------------------
    // two-stage synchroniser, then edge detection
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= raw_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign rise_now = sync_q & ~last_q;
    assign fall_o   = ~sync_q & last_q;

    // synchronised mode retimes the edge once more to the counter's phase
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rise_dly_q <= 1'b0;
        end else begin
            rise_dly_q <= rise_now;
        end
    end

    assign rise_o = bypass_i ? rise_now : rise_dly_q;

endmodule

/* tb/tmc_timer_chk.sv */
/* Port-level checker for tmc_timer: bus timing, counting, trigger,
   interrupt and pin relations.
   Assumes it is bound to tmc_timer and sees only its ports. */
`timescale 1ns/1ps
module tmc_timer_chk (
    input wire logic               mclk_i,
    input wire logic               srst_i,
    input wire logic               psel_i,
    input wire logic               penable_i,
    input wire logic               pwrite_i,
    input wire logic [7:0]         paddr_i,
    input wire logic               pready_o,
    input wire logic               pslverr_o,
    input wire logic [1:0]         port_c_direction_i,
    input wire logic [1:0]         port_c_latch_i,
    input wire logic [1:0]         pad_out_o,
    input wire logic [1:0]         pad_oe_o,
    input wire logic [3:0]         enhanced_cc_mode_field_i,
    input wire logic               enhanced_cc_match_i,
    input wire logic               cc_enh_use_this_o,
    input wire logic               cc_std_use_this_o,
    input wire logic [15:0]        count_o,
    input wire tmc_pkg::tmc_mode_t mode_o,
    input wire logic               irq_o
);
    import tmc_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic acc, cnt_wr, sm_wr, mapped, trig;
    assign acc    = psel_i && penable_i && pready_o;
    assign cnt_wr = acc && pwrite_i && (paddr_i == TMC_OFS_CNT_LO || paddr_i == TMC_OFS_CNT_HI);
    assign sm_wr  = acc && pwrite_i && (paddr_i == TMC_OFS_STATUS || paddr_i == TMC_OFS_MASK);
    assign mapped = paddr_i inside {TMC_OFS_CTRL, TMC_OFS_CNT_LO, TMC_OFS_CNT_HI,
                                    TMC_OFS_STATUS, TMC_OFS_MASK, TMC_OFS_AUX};
    assign trig   = enhanced_cc_match_i && enhanced_cc_mode_field_i == TMC_MODE_SPEV;

    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    // any write is excluded: a coinciding count write takes precedence
    sequence s_trig;
        trig && !(acc && pwrite_i) && mode_o != TMC_MODE_ASYNC;
    endsequence

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_ready_next: assert property (s_setup |=> pready_o)
        else $error("no answer after setup");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (pready_o |-> pslverr_o == !mapped)
        else $error("error response wrong for address");
    a_trig_clear: assert property (s_trig |=> count_o == 16'h0000)
        else $error("trigger did not clear count");
    a_count_step: assert property (!$past(srst_i) && !$past(cnt_wr) && !$past(trig)
        && count_o != $past(count_o) |-> count_o == $past(count_o) + 16'h0001)
        else $error("count moved by other than one");
    a_irq_fall: assert property ($fell(irq_o) |-> $past(sm_wr, 2))
        else $error("interrupt dropped without status or mask write");
    a_cc_order: assert property (cc_std_use_this_o |-> cc_enh_use_this_o)
        else $error("standard unit selected without enhanced unit");
    a_pad_oe: assert property (!$past(srst_i) && pad_oe_o != 2'b00
        |-> pad_oe_o == ~$past(port_c_direction_i))
        else $error("pad enable not from direction");
    a_pad_out: assert property (!$past(srst_i) |-> pad_out_o == $past(port_c_latch_i))
        else $error("pad output not from latch");
endmodule

/* tb/tmc_ext_src.sv */
/* Model of the far-side count sources: external count pin and
   companion oscillator.
   Assumes the caller picks the source and the half period in ns. */
`timescale 1ns/1ps
module tmc_ext_src (
    output logic pin_o,
    output logic osc_o
);
    // both idle low and stand still between bursts
    initial begin
        pin_o = 1'b0;
        osc_o = 1'b0;
    end

    // ------------------------------------------------------------
    // burst of rising edges, phase unrelated to mclk
    // ------------------------------------------------------------
    task automatic pulses(input int n, input bit osc, input int hp);
        repeat (n) begin
            #(hp);
            if (osc) osc_o = 1'b1; else pin_o = 1'b1;
            #(hp);
            if (osc) osc_o = 1'b0; else pin_o = 1'b0;
        end
    endtask
endmodule

/* tb/tb_tmc_timer.sv */
/* Self-checking testbench for tmc_timer.
   Assumes tmc_pkg, the design, tmc_ext_src and the checker are compiled first. */
`timescale 1ns/1ps
module tb_tmc_timer;
    import tmc_pkg::*;
    logic        clk, rst, sel, en, wr, match, rdy, err, ev, enh, std, irq;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, v;
    logic [1:0]  dir, lat, pin, pout, poe, prd;
    logic [3:0]  ccm;
    logic [15:0] cnt;
    tmc_mode_t   mode;
    wire         xin, osc;
    int          miscompares = 0, compares = 0, n;

    tmc_ext_src ext_u (.pin_o(xin), .osc_o(osc));
    tmc_timer dut_u (
        .mclk_i(clk), .srst_i(rst), .psel_i(sel), .penable_i(en), .pwrite_i(wr),
        .paddr_i(addr), .pwdata_i(wdata), .prdata_o(rdata), .pready_o(rdy),
        .pslverr_o(err), .ext_count_input_i(xin), .companion_osc_in_i(osc),
        .port_c_direction_i(dir), .port_c_latch_i(lat), .pad_in_i(pin),
        .pad_out_o(pout), .pad_oe_o(poe), .port_c_read_o(prd),
        .enhanced_cc_mode_field_i(ccm), .enhanced_cc_match_i(match),
        .cc_enh_use_this_o(enh), .cc_std_use_this_o(std), .count_o(cnt),
        .mode_o(mode), .irq_o(irq)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        sel <= 1'b1; en <= 1'b0; wr <= w; addr <= a; wdata <= d;
        @(posedge clk);
        en <= 1'b1;
        // no cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge clk);
        end while (rdy !== 1'b1);
        v = rdata;
        ev = err;
        sel <= 1'b0; en <= 1'b0;
    endtask

    // cycles between two successive count changes
    task automatic gap(output int g);
        logic [15:0] c;
        g = 0;
        c = cnt;
        while (cnt === c && g < 99) begin @(posedge clk); g++; end
        c = cnt;
        g = 0;
        while (cnt === c && g < 99) begin @(posedge clk); g++; end
    endtask

    task automatic pulse_trig;
        match <= 1'b1;
        @(posedge clk);
        match <= 1'b0;
        @(posedge clk);
    endtask

    task automatic finish_test;
        if (miscompares == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        apb(0, TMC_OFS_CTRL, 0); chk(v, {24'h0, TMC_CTRL_RST});
        apb(0, TMC_OFS_CNT_HI, 0); chk(v, 32'h0);
        apb(0, 8'h20, 0); chk(ev, 1);
    endtask

    task automatic t_div;
        logic [15:0] c;
        for (int d = 0; d < 4; d++) begin
            apb(1, TMC_OFS_CTRL, {d[1:0], 4'h1});
            apb(1, TMC_OFS_CNT_LO, 0);
            gap(n);
            chk(n, 1 << d);
        end
        chk(mode, TMC_MODE_TIMER);
        apb(1, TMC_OFS_CTRL, 0);
        repeat (2) @(posedge clk);
        c = cnt;
        repeat (20) @(posedge clk);
        chk(cnt, c);
        apb(1, TMC_OFS_CNT_LO, 5);
        apb(0, TMC_OFS_CNT_LO, 0); chk(v, 32'h5);
    endtask

    task automatic t_wide;
        apb(1, TMC_OFS_CTRL, 32'h80);
        apb(1, TMC_OFS_CNT_HI, 32'h12);
        apb(0, TMC_OFS_CNT_HI, 0); chk(v, 32'h12);
        chk(cnt, 16'h0005);
        apb(1, TMC_OFS_CNT_LO, 32'h34);
        @(posedge clk); chk(cnt, 16'h1234);
        apb(1, TMC_OFS_CNT_HI, 32'h77);
        apb(0, TMC_OFS_CNT_LO, 0); chk(v, 32'h34);
        apb(0, TMC_OFS_CNT_HI, 0); chk(v, 32'h12);
        apb(1, TMC_OFS_CTRL, 0);
        apb(1, TMC_OFS_CNT_HI, 32'h56);
        apb(0, TMC_OFS_CNT_HI, 0); chk(v, 32'h56);
    endtask

    task automatic t_ovf;
        apb(1, TMC_OFS_MASK, 1);
        apb(1, TMC_OFS_CTRL, 32'h80);
        apb(1, TMC_OFS_CNT_HI, 32'hff);
        apb(1, TMC_OFS_CNT_LO, 32'hfd);
        apb(0, TMC_OFS_STATUS, 0); chk(v, 32'h0);
        apb(1, TMC_OFS_CTRL, 32'h81);
        repeat (6) @(posedge clk);
        apb(0, TMC_OFS_STATUS, 0); chk(v, 32'h1);
        chk(irq, 1);
        apb(1, TMC_OFS_MASK, 0);
        repeat (2) @(posedge clk); chk(irq, 0);
        apb(1, TMC_OFS_STATUS, 1);
        apb(0, TMC_OFS_STATUS, 0); chk(v, 32'h0);
    endtask

    task automatic t_trig;
        ccm <= 4'ha;
        pulse_trig;
        chk(cnt === 16'h0000, 0);
        ccm <= TMC_MODE_SPEV;
        pulse_trig;
        chk(cnt, 16'h0000);
        apb(0, TMC_OFS_STATUS, 0); chk(v, 32'h0);
    endtask

    task automatic t_cc;
        for (int i = 0; i < 4; i++) begin
            apb(1, TMC_OFS_CTRL, {i[1], 2'b00, i[0], 3'b000});
            repeat (2) @(posedge clk);
            chk({enh, std}, {i[0] | i[1], i[1]});
        end
    endtask

    // b: 0 synced pin, 1 unsynced pin, 2 synced oscillator
    task automatic t_ext;
        for (int b = 0; b < 3; b++) begin
            apb(1, TMC_OFS_AUX, b == 2);
            apb(1, TMC_OFS_CTRL, 0);
            apb(1, TMC_OFS_CNT_LO, 0);
            apb(1, TMC_OFS_CNT_HI, 0);
            apb(1, TMC_OFS_CTRL, {b[0], 2'b11});
            ext_u.pulses(5, b == 2, 13);
            repeat (8) @(posedge clk);
            chk(mode, b[0] ? TMC_MODE_ASYNC : TMC_MODE_SYNC);
            chk(cnt, 16'h0004);
            chk({poe, prd}, b == 2 ? 4'h0 : 4'hf);
            pulse_trig;
            chk(cnt, b[0] ? 16'h0004 : 16'h0000);
        end
    endtask

    // ------------------------------------------------------------
    // clock, reset, sequence, watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        rst = 1'b1; sel = 1'b0; en = 1'b0; wr = 1'b0; addr = 8'h00; wdata = 32'h0;
        match = 1'b0; ccm = 4'h0; dir = 2'b00; lat = 2'b10; pin = 2'b11;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_div;
        t_wide;
        t_ovf;
        t_trig;
        t_cc;
        t_ext;
        finish_test;
    end

    // full run needs a few hundred cycles
    initial begin
        #60000;
        miscompares++;
        finish_test;
    end
endmodule

bind tmc_timer tmc_timer_chk chk_u (
    .mclk_i(mclk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .port_c_direction_i(port_c_direction_i), .port_c_latch_i(port_c_latch_i),
    .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
    .enhanced_cc_mode_field_i(enhanced_cc_mode_field_i),
    .enhanced_cc_match_i(enhanced_cc_match_i), .cc_enh_use_this_o(cc_enh_use_this_o),
    .cc_std_use_this_o(cc_std_use_this_o), .count_o(count_o), .mode_o(mode_o),
    .irq_o(irq_o)
);
